// ===== design/tag_ram_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants of the pipelined tag memory.
// ----------------------------------------------------------------------------
package tag_ram_pkg;

  // Organisation of the array.
  localparam int ADDR_W        = 16;
  localparam int DATA_W        = 18;
  localparam int ENTRIES       = 65536;

  // Cycles from a sampled command to its result on the pins.
  localparam int OUT_LATENCY   = 2;
  localparam int CMD_PIPE_DEPTH = 1;

  // Reset values of the input and output registers.
  localparam logic [ADDR_W-1:0] ADDR_RST  = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST  = 18'h0_0000;
  localparam logic              WSEL_RST  = 1'h1;
  localparam logic              SEL_RST   = 1'h0;

  // Level of the match output while the device is deselected.
  localparam logic              MATCH_IDLE = 1'h1;

endpackage : tag_ram_pkg

// ===== design/tag_array.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Single port storage array with a registered read port.
// ----------------------------------------------------------------------------
module tag_array #(
  parameter int AW = 16,
  parameter int DW = 18
) (
  input  wire logic          mclk,
  input  wire logic          wr_en,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata_ff
);

  logic [DW-1:0] store [0:(2**AW)-1];

  // A write lands in one edge; a read loads the read data register.
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      store[addr] <= wdata;
    end
    if (rd_en) begin
      rdata_ff <= store[addr];
    end
  end

endmodule : tag_array

// ===== design/cmd_pipe.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Resettable delay line that carries a command along the pipeline.
// ----------------------------------------------------------------------------
module cmd_pipe #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage_ff [0:DEPTH];

  assign stage_ff[0] = din;

  // One register per stage of delay.
  for (genvar i = 0; i < DEPTH; i++) begin : g_stage
    always_ff @(posedge mclk) begin
      if (srst) begin
        stage_ff[i+1] <= '0;
      end else begin
        stage_ff[i+1] <= stage_ff[i];
      end
    end
  end

  assign dout = stage_ff[DEPTH];

endmodule : cmd_pipe

// ===== design/pipelined_tag_ram_compare.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Pipelined tag memory with a built-in comparator.
// ----------------------------------------------------------------------------

// Summary of operation
// - Address, data, write select and both selects are registered every rising edge.
// - Input data register loads only when its load enable is sampled low.
// - Data and match output enables act at once, with no register.
// - Writes are timed inside, started by the clock edge, no external strobe.
// - Read data goes through an output register and drives two cycles later.
// - With the data output enable high the data bus stays undriven.
// - Write data comes with the write command and is registered then.
// - A compare is a read with output off, checked against loaded data.
// - Compare result sits in an output register, shown two cycles later.
// - Match is high when compare data equals the stored word, else low.
// - Match driver is on while its low-active enable is low.
// - The registered address picks one of 64K entries of 18 bits.
// - Two selects, one high-active and one low-active, must both be asserted.
// - Low write select means write, high means read, when selected.
// - Data output enable is gated by pipelined select and write copies.
// - Selected only with low-active select at 0 and high-active select at 1.
module pipelined_tag_ram_compare
  import tag_ram_pkg::*;
#(
  parameter int AW = tag_ram_pkg::ADDR_W,
  parameter int DW = tag_ram_pkg::DATA_W
) (
  input  wire logic          mclk,
  input  wire logic          srst,
  input  wire logic [AW-1:0] entry_address,
  input  wire logic [DW-1:0] dq_in,
  output logic      [DW-1:0] dq_out,
  output logic               dq_oe,
  input  wire logic          write_select_n,
  input  wire logic          select_high,
  input  wire logic          select_low_n,
  input  wire logic          input_load_enable_n,
  input  wire logic          data_out_enable_n,
  input  wire logic          match_out_enable_n,
  output logic               match_out,
  output logic               match_oe
);

  import tag_ram_pkg::*;

  // --------------------------------------------------------------------------
  // Input registers
  // --------------------------------------------------------------------------

  logic [AW-1:0] addr_ff;
  logic [DW-1:0] din_ff;
  logic          wsel_n_ff;
  logic          sel_high_ff;
  logic          sel_low_n_ff;
  logic [DW-1:0] nxt_din;

  // The data register keeps its contents unless the load enable is low.
  assign nxt_din = input_load_enable_n ? din_ff : dq_in;

  // All synchronous inputs are captured as they are, without inversion.
  always_ff @(posedge mclk) begin
    if (srst) begin
      addr_ff      <= ADDR_RST;
      din_ff       <= DATA_RST;
      wsel_n_ff    <= WSEL_RST;
      sel_high_ff  <= SEL_RST;
      sel_low_n_ff <= ~SEL_RST;
    end else begin
      addr_ff      <= entry_address;
      din_ff       <= nxt_din;
      wsel_n_ff    <= write_select_n;
      sel_high_ff  <= select_high;
      sel_low_n_ff <= select_low_n;
    end
  end

  // --------------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------------

  logic selected;
  logic rd_cmd;
  logic wr_cmd;

  // Both selects must be asserted; any other mix deselects the part.
  assign selected = sel_high_ff & ~sel_low_n_ff;
  // A low write select is a write, a high one is a read or compare.
  assign rd_cmd   = selected & wsel_n_ff;
  assign wr_cmd   = selected & ~wsel_n_ff;

  // --------------------------------------------------------------------------
  // Storage array
  // --------------------------------------------------------------------------

  logic [DW-1:0] rd_data;

  // The write is started by the edge after the command is registered and
  // completes within that one edge, so no strobe is needed from outside.
  tag_array #(
    .AW (AW),
    .DW (DW)
  ) u_array (
    .mclk     (mclk),
    .wr_en    (wr_cmd),
    .rd_en    (rd_cmd),
    .addr     (addr_ff),
    .wdata    (din_ff),
    .rdata_ff (rd_data)
  );

  // --------------------------------------------------------------------------
  // Command pipeline
  // --------------------------------------------------------------------------

  logic [DW+1:0] pipe_in;
  logic [DW+1:0] pipe_out;
  logic          rd_s1;
  logic          sel_s1;
  logic [DW-1:0] cmp_s1;

  // The compare value travels beside the read so a new load cannot spoil it.
  assign pipe_in = {rd_cmd, selected, din_ff};

  cmd_pipe #(
    .WIDTH (DW + 2),
    .DEPTH (CMD_PIPE_DEPTH)
  ) u_pipe (
    .mclk (mclk),
    .srst (srst),
    .din  (pipe_in),
    .dout (pipe_out)
  );

  assign rd_s1  = pipe_out[DW+1];
  assign sel_s1 = pipe_out[DW];
  assign cmp_s1 = pipe_out[DW-1:0];

  // --------------------------------------------------------------------------
  // Output registers
  // --------------------------------------------------------------------------

  logic [DW-1:0] dq_out_ff;
  logic          rd_valid_ff;
  logic          match_ff;
  logic          cmp_equal;
  logic [DW-1:0] nxt_dq_out;
  logic          nxt_match;

  // Equality of the stored word and the delayed compare value.
  assign cmp_equal  = (rd_data == cmp_s1);
  assign nxt_dq_out = rd_s1 ? rd_data : dq_out_ff;
  // Deselected cycles pull match high; writes leave it as it was.
  assign nxt_match  = !sel_s1 ? MATCH_IDLE :
                      rd_s1   ? cmp_equal  : match_ff;

  // Second pipeline stage: read data, read-valid flag and match result.
  always_ff @(posedge mclk) begin
    if (srst) begin
      dq_out_ff   <= DATA_RST;
      rd_valid_ff <= 1'h0;
      match_ff    <= MATCH_IDLE;
    end else begin
      dq_out_ff   <= nxt_dq_out;
      rd_valid_ff <= rd_s1;
      match_ff    <= nxt_match;
    end
  end

  // --------------------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------------------

  // Enables act immediately; only a pipelined selected read may drive data.
  assign dq_oe     = ~data_out_enable_n & rd_valid_ff;
  assign match_oe  = ~match_out_enable_n;
  assign dq_out    = dq_out_ff;
  assign match_out = match_ff;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------

  logic sel_in;
  logic rd_in;
  logic wr_in;

  // Decode of the raw pins, used only by the checks below.
  assign sel_in = select_high & ~select_low_n;
  assign rd_in  = sel_in & write_select_n;
  assign wr_in  = sel_in & ~write_select_n;

  chk_input_capture: assert property (
    @(posedge mclk) disable iff (srst)
    1'b1 |=> (addr_ff == $past(entry_address)) && (wsel_n_ff == $past(write_select_n))
  ) else $error("Inputs were not registered on the edge.");

  chk_load_hold: assert property (
    @(posedge mclk) disable iff (srst)
    input_load_enable_n |=> $stable(din_ff)
  ) else $error("Input data changed while its load enable was high.");

  chk_load_take: assert property (
    @(posedge mclk) disable iff (srst)
    !input_load_enable_n |=> (din_ff == $past(dq_in))
  ) else $error("Write data was not taken with the command.");

  chk_write_start: assert property (
    @(posedge mclk) disable iff (srst)
    wr_in |=> wr_cmd && !rd_cmd && (addr_ff == $past(entry_address))
  ) else $error("Write was not started on the edge after the command.");

  chk_read_latency: assert property (
    @(posedge mclk) disable iff (srst)
    rd_in |-> ##3 (rd_valid_ff && (dq_oe == !data_out_enable_n))
  ) else $error("Read data not presented two cycles after the command.");

  chk_oe_off: assert property (
    @(posedge mclk) disable iff (srst)
    data_out_enable_n |-> !dq_oe
  ) else $error("Data bus driven while its output enable was high.");

  chk_write_quiet: assert property (
    @(posedge mclk) disable iff (srst)
    wr_in |-> ##3 !dq_oe
  ) else $error("Data bus driven in the result slot of a write.");

  chk_match_value: assert property (
    @(posedge mclk) disable iff (srst)
    rd_s1 |=> (match_ff == $past(cmp_equal)) && (dq_out_ff == $past(rd_data))
  ) else $error("Compare result does not follow the stored word.");

  chk_match_latency: assert property (
    @(posedge mclk) disable iff (srst)
    rd_in ##1 1'b1 |-> ##2 (match_out == $past(cmp_equal))
  ) else $error("Match result not shown two cycles after the compare.");

  chk_match_enable: assert property (
    @(posedge mclk) disable iff (srst)
    match_oe != match_out_enable_n
  ) else $error("Match driver does not follow its enable.");

  chk_deselect_idle: assert property (
    @(posedge mclk) disable iff (srst)
    !sel_in |-> ##3 (!rd_valid_ff && match_ff)
  ) else $error("Deselected cycle produced a read or a low match.");

  chk_compare_pair: assert property (
    @(posedge mclk) disable iff (srst)
    rd_cmd |=> rd_s1 && (cmp_s1 == $past(din_ff))
  ) else $error("Compare value lost its pairing with the read.");

  chk_select_capture: assert property (
    @(posedge mclk) disable iff (srst)
    1'b1 |=> (sel_high_ff == $past(select_high)) && (sel_low_n_ff == $past(select_low_n))
  ) else $error("Select inputs were not registered on the edge.");

  chk_select_decode: assert property (
    @(posedge mclk) disable iff (srst)
    sel_in |=> selected
  ) else $error("Both selects asserted but the part was not selected.");

  chk_partial_select: assert property (
    @(posedge mclk) disable iff (srst)
    !sel_in |=> !rd_cmd && !wr_cmd
  ) else $error("A partial select still started a command.");

  chk_read_decode: assert property (
    @(posedge mclk) disable iff (srst)
    rd_in |=> rd_cmd && !wr_cmd
  ) else $error("A high write select did not decode as a read.");

  chk_oe_immediate: assert property (
    @(posedge mclk) disable iff (srst)
    (!data_out_enable_n && rd_valid_ff) |-> dq_oe
  ) else $error("Data driver did not follow its enable at once.");

  chk_read_data: assert property (
    @(posedge mclk) disable iff (srst)
    rd_in |-> ##3 (dq_out == $past(rd_data))
  ) else $error("Read data on the bus is not the word read from the array.");

  chk_write_holds_match: assert property (
    @(posedge mclk) disable iff (srst)
    wr_in |-> ##3 $stable(match_out)
  ) else $error("Match output changed in the result slot of a write.");

  chk_compare_hit: assert property (
    @(posedge mclk) disable iff (srst)
    (rd_s1 && (rd_data == cmp_s1)) |=> match_ff
  ) else $error("Equal compare data did not raise the match output.");

  chk_compare_miss: assert property (
    @(posedge mclk) disable iff (srst)
    (rd_s1 && (rd_data != cmp_s1)) |=> !match_ff
  ) else $error("Differing compare data did not lower the match output.");

  chk_write_lands: assert property (
    @(posedge mclk) disable iff (srst)
    wr_cmd ##1 (rd_cmd && (addr_ff == $past(addr_ff))) |=> (rd_data == $past(din_ff, 2))
  ) else $error("Written entry does not hold the input register contents.");

endmodule : pipelined_tag_ram_compare

// ===== verif/ctl_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Cache controller model that drives the command pins of the tag memory.
// ----------------------------------------------------------------------------
module ctl_model (
  input  wire logic                           mclk,
  output logic      [tag_ram_pkg::ADDR_W-1:0] entry_address,
  output logic      [tag_ram_pkg::DATA_W-1:0] dq_drive,
  output logic                                dq_drive_en,
  output logic                                write_select_n,
  output logic                                select_high,
  output logic                                select_low_n,
  output logic                                input_load_enable_n,
  output logic                                data_out_enable_n,
  output logic                                match_out_enable_n
);
  import tag_ram_pkg::*;

  logic [2:0] wr_hist;

  // Pins rest in the deselected state until the first command.
  initial begin
    entry_address       = 16'h0000;
    dq_drive            = 18'h0_0000;
    dq_drive_en         = 1'b0;
    write_select_n      = 1'b1;
    select_high         = 1'b0;
    select_low_n        = 1'b1;
    input_load_enable_n = 1'b1;
    data_out_enable_n   = 1'b1;
    match_out_enable_n  = 1'b1;
    wr_hist             = 3'h0;
  end

  // Drives one command just after a rising edge; the bus is only driven with load data.
  task automatic issue(input logic sh, input logic sl_n, input logic wr_n, input logic ld_n,
                       input logic oe_n, input logic moe_n, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
    @(posedge mclk);
    entry_address       <= a;
    dq_drive            <= d;
    dq_drive_en         <= !ld_n;
    write_select_n      <= wr_n;
    select_high         <= sh;
    select_low_n        <= sl_n;
    input_load_enable_n <= ld_n;
    match_out_enable_n  <= moe_n;
    // Output stays off while we drive, on every write and for the three commands after it.
    data_out_enable_n   <= oe_n | !ld_n | !wr_n | (|wr_hist);
    wr_hist             <= {wr_hist[1:0], !wr_n};
  endtask : issue
endmodule : ctl_model

// ===== verif/testbench.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Self-checking bench for the pipelined tag memory.
// ----------------------------------------------------------------------------
module testbench;
  import tag_ram_pkg::*;

  logic              mclk;
  logic              srst;
  wire  [ADDR_W-1:0] entry_address;
  wire  [DATA_W-1:0] dq_drive;
  wire  [DATA_W-1:0] dq_out;
  wire  [DATA_W-1:0] dq_bus;
  wire               dq_drive_en;
  wire               dq_oe;
  wire               write_select_n;
  wire               select_high;
  wire               select_low_n;
  wire               input_load_enable_n;
  wire               data_out_enable_n;
  wire               match_out_enable_n;
  wire               match_out;
  wire               match_oe;
  wire               match_pin;
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] dreg;
  logic [DATA_W-1:0] last_dq;
  logic              last_m;
  logic [DATA_W-1:0] q_dq [$];
  logic              q_m [$];
  logic              q_rv [$];
  logic [31:0]       r;
  int                seed;
  int                mismatches;
  int                comparisons;
  int                cycles;

  // Shared wires resolved from every driver's enable.
  assign dq_bus    = dq_oe ? dq_out : (dq_drive_en ? dq_drive : 'z);
  assign match_pin = match_oe ? match_out : 1'bz;

  pipelined_tag_ram_compare u_pipelined_tag_ram_compare (
    .mclk                (mclk),
    .srst                (srst),
    .entry_address       (entry_address),
    .dq_in               (dq_bus),
    .dq_out              (dq_out),
    .dq_oe               (dq_oe),
    .write_select_n      (write_select_n),
    .select_high         (select_high),
    .select_low_n        (select_low_n),
    .input_load_enable_n (input_load_enable_n),
    .data_out_enable_n   (data_out_enable_n),
    .match_out_enable_n  (match_out_enable_n),
    .match_out           (match_out),
    .match_oe            (match_oe)
  );

  ctl_model u_ctl_model (
    .mclk                (mclk),
    .entry_address       (entry_address),
    .dq_drive            (dq_drive),
    .dq_drive_en         (dq_drive_en),
    .write_select_n      (write_select_n),
    .select_high         (select_high),
    .select_low_n        (select_low_n),
    .input_load_enable_n (input_load_enable_n),
    .data_out_enable_n   (data_out_enable_n),
    .match_out_enable_n  (match_out_enable_n)
  );

  // Free-running clock of 4 ns.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Cuts a hang short once the run is far past its expected length.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      mismatches = mismatches + 1;
      results();
    end
  end

  // Compares one value and reports a difference at once.
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected value at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check

  // Issues one command, updates the model and checks the result due three commands back.
  task automatic step(input logic sh, input logic sl_n, input logic wr_n, input logic ld_n,
                      input logic oe_n, input logic moe_n, input logic [2:0] k,
                      input logic [DATA_W-1:0] d);
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] ed;
    logic              em;
    logic              rv;
    a = ADDR_W'(k * 16'h2001);
    rv = sh & !sl_n & wr_n;
    u_ctl_model.issue(sh, sl_n, wr_n, ld_n, oe_n, moe_n, a, d);
    if (!ld_n) dreg = d;
    if (!(sh & !sl_n)) last_m = 1'b1;
    else if (!wr_n) mem[a] = dreg;
    else begin
      last_dq = mem[a];
      last_m = (mem[a] === dreg);
    end
    q_dq.push_back(last_dq);
    q_m.push_back(last_m);
    q_rv.push_back(rv);
    @(negedge mclk);
    ed = q_dq.pop_front();
    em = q_m.pop_front();
    rv = q_rv.pop_front();
    check(dq_out, ed);
    check(DATA_W'(dq_oe), DATA_W'(rv & !data_out_enable_n));
    check(DATA_W'(match_out), DATA_W'(em));
    check(DATA_W'(match_oe), DATA_W'(!match_out_enable_n));
    check(DATA_W'(match_pin), DATA_W'(match_out_enable_n ? 1'bz : em));
  endtask : step

  // Prints the verdict and ends the run.
  task automatic results();
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // Reset, fill every entry used, then random back-to-back traffic.
  initial begin
    seed = 3;
    srst = 1'b1;
    mismatches = 0;
    comparisons = 0;
    cycles = 0;
    dreg = DATA_RST;
    last_dq = DATA_RST;
    last_m = MATCH_IDLE;
    r = 32'h0000_0000;
    repeat (3) q_dq.push_back(DATA_RST);
    repeat (3) q_m.push_back(MATCH_IDLE);
    repeat (3) q_rv.push_back(1'b0);
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      step(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, i[2:0], 18'h2_5A00 + DATA_W'(i));
    end
    for (int i = 0; i < 400; i++) begin
      r = $random(seed);
      step(r[4:3] != 2'h0, r[6:5] == 2'h0, r[7], r[8], r[9], r[10], r[13:11],
           18'h1_2340 + DATA_W'(r[15:14]));
    end
    results();
  end
endmodule : testbench
